//--- pkg/ui_irq_defs.svh
// constants for the usb interrupt and error logic
// assumes: included by bare name from the package and the bench
`ifndef UI_IRQ_DEFS_SVH
`define UI_IRQ_DEFS_SVH
// ----------------------------------------------------------------
// bus decode
// ----------------------------------------------------------------
`define UI_ADDR_W        12
`define UI_OFS_ST_FLAGS  12'h000
`define UI_OFS_ST_EN     12'h004
`define UI_OFS_ER_FLAGS  12'h008
`define UI_OFS_ER_EN     12'h00C
`define UI_OFS_CTRL      12'h010
`define UI_HTRANS_NSEQ   2'h2
// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define UI_ST_SOF        6
`define UI_ST_STALL      5
`define UI_ST_IDLE       4
`define UI_ST_TRN        3
`define UI_ST_ACTV       2
`define UI_ST_ERR        1
`define UI_ST_URST       0
`define UI_ER_STUFF      7
`define UI_ER_TOUT       4
`define UI_ER_FSIZE      3
`define UI_ER_DCRC       2
`define UI_ER_TCRC       1
`define UI_ER_PID        0
`define UI_CTRL_SUSP     0
`define UI_CTRL_PLL      1
`define UI_CTRL_READY    2
`define UI_ST_MASK       8'h7F
`define UI_ST_WR_MASK    8'h7D
`define UI_ER_MASK       8'h9F
`define UI_REG_RST       8'h00
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define UI_CLK_MHZ       250
`define UI_RESYNC_NS     16
`define UI_RESYNC_CYC    ((`UI_RESYNC_NS * `UI_CLK_MHZ + 999) / 1000)
`define UI_TURN_BITS     16
`define UI_TURN_W        5
`endif

//--- pkg/ui_irq_pkg.sv
// types shared by the usb interrupt and error logic
// assumes: ui_irq_defs.svh is on the include path
`include "ui_irq_defs.svh"
package ui_irq_pkg;
  // ----------------------------------------------------------------
  // event carriers from the serial interface engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic frame_start;
    logic stall_sent;
    logic idle_detect;
    logic transaction_done;
    logic bus_activity;
    logic bus_reset;
  } ui_stat_ev_s;

  typedef struct packed {
    logic stuff_error;
    logic field_size_error;
    logic data_crc_error;
    logic token_crc_error;
    logic pid_check_error;
  } ui_err_ev_s;

  typedef enum logic [1:0] {
    GD_RUN,
    GD_SUSP,
    GD_PLL,
    GD_SYNC
  } ui_guard_e;

  typedef struct packed {
    ui_guard_e  st;
    logic [3:0] cnt;
  } ui_guard_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } ui_sync_s;

  typedef struct packed {
    logic [7:0]           st_flags;
    logic [7:0]           st_en;
    logic [7:0]           er_flags;
    logic [7:0]           er_en;
    logic                 suspend;
    logic                 pll_src;
    logic                 ph_wr;
    logic [`UI_ADDR_W-1:0] ph_addr;
    logic [31:0]          hrdata;
    logic                 rdy;
    logic                 irq;
    logic                 mod_ready;
    logic                 turn_arm;
    logic [`UI_TURN_W-1:0] turn_cnt;
  } ui_core_s;
endpackage

//--- core/ui_sync3.sv
// three-stage synchroniser with agreement filter
// assumes: i_async may change at any time relative to i_ref_clk
`timescale 1ns/1ps
module ui_sync3
  import ui_irq_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  input  wire logic i_async,
  output logic      o_level
);
  ui_sync_s q;
  ui_sync_s d;

  // ----------------------------------------------------------------
  // s1 feeds only s2; the level moves once s2 and s3 agree
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.s1 = i_async;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.lvl = q.s3;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.lvl;
endmodule

//--- core/ui_wake_guard.sv
// tracks suspend, pll relock and resync after wake
// assumes: i_pll_locked is already synchronised to i_ref_clk
`timescale 1ns/1ps
module ui_wake_guard
  import ui_irq_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  input  wire logic i_suspend,
  input  wire logic i_pll_src,
  input  wire logic i_pll_locked,
  output logic      o_clear_ok,
  output logic      o_ready
);
  ui_guard_s q;
  ui_guard_s d;

  always_comb begin
    d = q;
    unique case (q.st)
      GD_RUN: begin
        if (i_suspend) begin
          d.st = GD_SUSP;
        end
      end
      GD_SUSP: begin
        if (!i_suspend) begin
          d.cnt = 4'(`UI_RESYNC_CYC);
          d.st  = i_pll_src ? GD_PLL : GD_SYNC;
        end
      end
      GD_PLL: begin
        if (i_suspend) begin
          d.st = GD_SUSP;
        end else if (i_pll_locked) begin
          d.st = GD_SYNC;
        end
      end
      GD_SYNC: begin
        if (i_suspend) begin
          d.st = GD_SUSP;
        end else if (q.cnt <= 4'h1) begin
          d.st = GD_RUN;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // suspend blocks clears in the same cycle it is set
  assign o_clear_ok = (q.st == GD_RUN) && !i_suspend;
  assign o_ready    = (q.st == GD_RUN);
endmodule

//--- core/ui_irq_core.sv
// usb interrupt status, enables, error flags and request funnel
// assumes: engine event inputs are one-cycle pulses on i_ref_clk;
// assumes: i_pll_locked comes from another domain; ahb-lite single master
//
// Notes on behaviour
// - activity flag ignores clears while suspended and briefly after waking
// - with pll clocking, module stays not ready after wake until lock
// - status enable register: seven enables, bit 7 zero, reset zero
// - enables gate only the request; flags always set by events
// - enabled error flags are ORed into the error summary flag
// - error flags set in the cycle the condition is seen
// - error flag stays set until software writes zero to it
// - bit 7 error flag set on bit stuff violation
// - turnaround flag set after more than sixteen idle bit times
// - field size flag set when data is not whole bytes
// - data crc flag set on crc16 failure
// - token crc flag set when token rejected for crc5
// - bit 0 error flag set on pid check failure
// - error flag and enable bits 6 and 5 read zero
// - error enables mirror flag positions, reset zero, gate summary only
// - enabled status flags ORed into one module request
// - error summary is read-only, writes have no effect
// - status flags may be set by software writes
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module ui_irq_core
  import ui_irq_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_resetn,
  // ahb-lite slave
  input  wire logic                  i_hsel,
  input  wire logic [`UI_ADDR_W-1:0] i_haddr,
  input  wire logic [1:0]            i_htrans,
  input  wire logic                  i_hwrite,
  input  wire logic [2:0]            i_hsize,
  input  wire logic [31:0]           i_hwdata,
  input  wire logic                  i_hready,
  output logic [31:0]                o_hrdata,
  output logic                       o_hreadyout,
  output logic                       o_hresp,
  // serial interface engine
  input  wire ui_stat_ev_s           i_stat_ev,
  input  wire ui_err_ev_s            i_err_ev,
  input  wire logic                  i_eop_done,
  input  wire logic                  i_expect_reply,
  input  wire logic                  i_rx_start,
  input  wire logic                  i_bit_tick,
  // clocking
  input  wire logic                  i_pll_locked,
  // outputs
  output logic                       o_module_irq_request,
  output logic [7:0]                 o_usb_status_flags,
  output logic [7:0]                 o_usb_error_flags,
  output logic                       o_suspend_control,
  output logic                       o_module_ready
);
  ui_core_s q;
  ui_core_s d;

  logic pll_locked_sync;
  logic clear_ok;
  logic ready;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [`UI_ADDR_W-1:0] a,
                               input logic [`UI_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic err_sum(input logic [7:0] fl,
                                   input logic [7:0] en);
    err_sum = |(fl & en & `UI_ER_MASK);
  endfunction

  function automatic logic [7:0] stat_view(input logic [7:0] fl,
                                           input logic       sum);
    logic [7:0] v;
    v = fl & `UI_ST_WR_MASK;
    v[`UI_ST_ERR] = sum;
    stat_view = v;
  endfunction

  // ----------------------------------------------------------------
  // crossing and wake tracking
  // ----------------------------------------------------------------
  ui_sync3 u_pll_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_pll_locked),
    .o_level   (pll_locked_sync)
  );

  ui_wake_guard u_guard (
    .i_ref_clk    (i_ref_clk),
    .i_resetn     (i_resetn),
    .i_suspend    (q.suspend),
    .i_pll_src    (q.pll_src),
    .i_pll_locked (pll_locked_sync),
    .o_clear_ok   (clear_ok),
    .o_ready      (ready)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [7:0] st_set;
  logic [7:0] er_set;
  logic [7:0] st_wr;
  logic [7:0] er_keep;
  logic       turn_fire;
  logic       addr_phase;
  logic       sum_d;
  logic [7:0] rd_byte;
  logic [7:0] ctrl_view;

  always_comb begin
    d         = q;
    st_set    = `UI_REG_RST;
    er_set    = `UI_REG_RST;
    st_wr     = q.st_flags;
    er_keep   = 8'hFF;
    turn_fire = 1'b0;
    rd_byte   = `UI_REG_RST;
    ctrl_view = `UI_REG_RST;
    d.rdy     = 1'b1;
    // ready output lags the guard by one register stage
    d.mod_ready = ready;

    // turnaround watch: counts idle bit times after an eop
    if (i_rx_start) begin
      d.turn_arm = 1'b0;
      d.turn_cnt = '0;
    end else if (i_eop_done && i_expect_reply) begin
      d.turn_arm = 1'b1;
      d.turn_cnt = '0;
    end else if (q.turn_arm && i_bit_tick) begin
      if (q.turn_cnt == `UI_TURN_W'(`UI_TURN_BITS)) begin
        turn_fire  = 1'b1;
        d.turn_arm = 1'b0;
        d.turn_cnt = '0;
      end else begin
        d.turn_cnt = q.turn_cnt + `UI_TURN_W'(1);
      end
    end

    // events set flags regardless of any enable
    st_set[`UI_ST_SOF]   = i_stat_ev.frame_start;
    st_set[`UI_ST_STALL] = i_stat_ev.stall_sent;
    st_set[`UI_ST_IDLE]  = i_stat_ev.idle_detect;
    st_set[`UI_ST_TRN]   = i_stat_ev.transaction_done;
    st_set[`UI_ST_ACTV]  = i_stat_ev.bus_activity;
    st_set[`UI_ST_URST]  = i_stat_ev.bus_reset;
    er_set[`UI_ER_STUFF] = i_err_ev.stuff_error;
    er_set[`UI_ER_TOUT]  = turn_fire;
    er_set[`UI_ER_FSIZE] = i_err_ev.field_size_error;
    er_set[`UI_ER_DCRC]  = i_err_ev.data_crc_error;
    er_set[`UI_ER_TCRC]  = i_err_ev.token_crc_error;
    er_set[`UI_ER_PID]   = i_err_ev.pid_check_error;

    // data phase of a write
    if (q.ph_wr) begin
      if (hit(q.ph_addr, `UI_OFS_ST_FLAGS)) begin
        st_wr = i_hwdata[7:0] & `UI_ST_WR_MASK;
        if (!clear_ok) begin
          st_wr[`UI_ST_ACTV] = q.st_flags[`UI_ST_ACTV] | i_hwdata[`UI_ST_ACTV];
        end
      end
      if (hit(q.ph_addr, `UI_OFS_ST_EN)) begin
        d.st_en = i_hwdata[7:0] & `UI_ST_MASK;
      end
      if (hit(q.ph_addr, `UI_OFS_ER_FLAGS)) begin
        er_keep = i_hwdata[7:0];
      end
      if (hit(q.ph_addr, `UI_OFS_ER_EN)) begin
        d.er_en = i_hwdata[7:0] & `UI_ER_MASK;
      end
      if (hit(q.ph_addr, `UI_OFS_CTRL)) begin
        d.suspend = i_hwdata[`UI_CTRL_SUSP];
        d.pll_src = i_hwdata[`UI_CTRL_PLL];
      end
    end

    // set wins over a clear landing in the same cycle
    d.st_flags = (st_wr | st_set) & `UI_ST_WR_MASK;
    d.er_flags = ((q.er_flags & er_keep) | er_set) & `UI_ER_MASK;

    sum_d = err_sum(d.er_flags, d.er_en);

    // registered request mirrors the flags it follows
    d.irq = |(stat_view(d.st_flags, sum_d) & d.st_en & `UI_ST_MASK);

    // address phase: reads see this cycle's updated contents
    addr_phase = i_hsel && i_hready && (i_htrans == `UI_HTRANS_NSEQ);
    ctrl_view[`UI_CTRL_SUSP]  = d.suspend;
    ctrl_view[`UI_CTRL_PLL]   = d.pll_src;
    ctrl_view[`UI_CTRL_READY] = ready;
    if (hit(i_haddr, `UI_OFS_ST_FLAGS)) begin
      rd_byte = stat_view(d.st_flags, sum_d);
    end else if (hit(i_haddr, `UI_OFS_ST_EN)) begin
      rd_byte = d.st_en;
    end else if (hit(i_haddr, `UI_OFS_ER_FLAGS)) begin
      rd_byte = d.er_flags;
    end else if (hit(i_haddr, `UI_OFS_ER_EN)) begin
      rd_byte = d.er_en;
    end else if (hit(i_haddr, `UI_OFS_CTRL)) begin
      rd_byte = ctrl_view;
    end

    d.ph_wr = 1'b0;
    if (addr_phase) begin
      d.ph_wr   = i_hwrite;
      d.ph_addr = i_haddr;
      d.hrdata  = i_hwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      q       <= '0;
      q.rdy   <= 1'b1;
    end else begin
      q       <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_hrdata             = q.hrdata;
  assign o_hreadyout          = q.rdy;
  assign o_hresp              = 1'b0;
  assign o_module_irq_request = q.irq;
  assign o_usb_status_flags   = q.st_flags;
  assign o_usb_error_flags    = q.er_flags;
  assign o_suspend_control    = q.suspend;
  assign o_module_ready       = q.mod_ready;

  // hsize unused: every register sits in the low byte of its word
  logic unused_hsize;
  assign unused_hsize = ^i_hsize;
endmodule

//--- tb/ui_irq_core_monitor.sv
// port checker for the usb interrupt core
// assumes: bound onto ui_irq_core; engine events are one-cycle pulses
`timescale 1ns/1ps
module ui_irq_core_monitor
  import ui_irq_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire ui_stat_ev_s i_stat_ev,
  input  wire ui_err_ev_s  i_err_ev,
  input  wire logic        o_hreadyout,
  input  wire logic        o_hresp,
  input  wire logic        o_module_irq_request,
  input  wire logic [7:0]  o_usb_status_flags,
  input  wire logic [7:0]  o_usb_error_flags,
  input  wire logic        o_suspend_control,
  input  wire logic        o_module_ready
);
  logic [7:0] ev_er;
  logic [7:0] ev_st;
  // events placed at their flag positions
  assign ev_er = {i_err_ev[4], 3'h0, i_err_ev[3:0]};
  assign ev_st = {1'h0, i_stat_ev[5:1], 1'h0, i_stat_ev[0]};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  bus_okay_a: assert property (
    o_hreadyout && !o_hresp) else $error("bus not ready or not okay");
  er_set_a: assert property (
    |ev_er |=> (o_usb_error_flags & $past(ev_er)) == $past(ev_er))
    else $error("error flag missed its event");
  st_set_a: assert property (
    |ev_st |=> (o_usb_status_flags & $past(ev_st)) == $past(ev_st))
    else $error("status flag missed its event");
  er_rise_a: assert property (
    (o_usb_error_flags & ~$past(o_usb_error_flags) & 8'h8F & ~$past(ev_er)) == 8'h00)
    else $error("error flag rose without event");
  rsvd_zero_a: assert property (
    o_usb_error_flags[6:5] == 2'h0 && o_usb_status_flags[7] == 1'h0)
    else $error("unimplemented bit set");
  irq_src_a: assert property (
    o_module_irq_request |-> (o_usb_status_flags | o_usb_error_flags) != 8'h00)
    else $error("request without any flag");
  susp_ready_a: assert property (
    o_suspend_control [*4] |-> !o_module_ready) else $error("ready while suspended");
  wake_wait_a: assert property (
    o_suspend_control ##1 !o_suspend_control |-> !o_module_ready [*4])
    else $error("ready too soon");
endmodule

//--- tb/ui_sie_model.sv
// engine-side model: event pulses, packet ends, bit ticks, pll lock
// assumes: the bench calls one task at a time
`timescale 1ns/1ps
module ui_sie_model
  import ui_irq_pkg::*;
(
  input  wire logic  i_ref_clk,
  output ui_stat_ev_s o_stat_ev,
  output ui_err_ev_s  o_err_ev,
  output logic        o_eop_done,
  output logic        o_expect_reply,
  output logic        o_rx_start,
  output logic        o_bit_tick,
  output logic        o_pll_locked
);
  initial begin
    o_stat_ev = '0;
    o_err_ev = '0;
    o_eop_done = 1'h0;
    o_expect_reply = 1'h0;
    o_rx_start = 1'h0;
    o_bit_tick = 1'h0;
    o_pll_locked = 1'h1;
  end
  task automatic st(input int k);
    @(posedge i_ref_clk);
    o_stat_ev <= ui_stat_ev_s'(6'h01 << k);
    @(posedge i_ref_clk);
    o_stat_ev <= '0;
  endtask
  task automatic err(input int k);
    @(posedge i_ref_clk);
    o_err_ev <= ui_err_ev_s'(5'h01 << k);
    @(posedge i_ref_clk);
    o_err_ev <= '0;
  endtask
  // packet end, then the reply start if the host answers
  task automatic eop(input logic ex, input logic rx);
    @(posedge i_ref_clk);
    o_eop_done <= 1'h1;
    o_expect_reply <= ex;
    @(posedge i_ref_clk);
    o_eop_done <= 1'h0;
    o_rx_start <= rx;
    @(posedge i_ref_clk);
    o_rx_start <= 1'h0;
  endtask
  // ticks are spaced to keep the run short, not at real bit rate
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_ref_clk);
      o_bit_tick <= 1'h1;
      @(posedge i_ref_clk);
      o_bit_tick <= 1'h0;
    end
  endtask
  // lock is asynchronous, so it moves off the clock edge
  task automatic lock(input logic v);
    @(posedge i_ref_clk);
    #1 o_pll_locked = v;
  endtask
endmodule

//--- tb/tb_usb_interrupt_error_logic.sv
// bench for the usb interrupt core: ahb-lite master and read scoreboard
// assumes: package, defs header and design compiled before this file
`timescale 1ns/1ps
`include "ui_irq_defs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tb_usb_interrupt_error_logic
  import ui_irq_pkg::*;
;
  logic                  clk, resetn, hsel, hwrite, rd_ph;
  logic                  eop, exr, rxs, tick, lock, irq, susp, rdy, hrdy, hresp;
  logic [`UI_ADDR_W-1:0] haddr;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           hwdata, hrdata, exp;
  logic [7:0]            stf, erf, m, r;
  ui_stat_ev_s           sev;
  ui_err_ev_s            eev;
  logic [31:0]           q[$];
  int                    fails, n_checks, n;
  ui_irq_core i_dut (.i_ref_clk(clk), .i_resetn(resetn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_stat_ev(sev), .i_err_ev(eev), .i_eop_done(eop), .i_expect_reply(exr),
    .i_rx_start(rxs), .i_bit_tick(tick), .i_pll_locked(lock),
    .o_module_irq_request(irq), .o_usb_status_flags(stf), .o_usb_error_flags(erf),
    .o_suspend_control(susp), .o_module_ready(rdy));
  ui_sie_model i_sie (.i_ref_clk(clk), .o_stat_ev(sev), .o_err_ev(eev), .o_eop_done(eop),
    .o_expect_reply(exr), .o_rx_start(rxs), .o_bit_tick(tick), .o_pll_locked(lock));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // -------- read scoreboard --------
  always @(posedge clk) begin
    if (rd_ph && hrdy) begin
      exp = q.pop_front();
      `CHK(hrdata, exp)
    end
  end
  task automatic conclude;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // every transfer ends just after an edge, so callers may check at #1
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    if (!w) q.push_back({24'h000000, d});
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= `UI_HTRANS_NSEQ;
    hsize <= 3'h2;
    @(posedge clk);
    while (hrdy !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    rd_ph <= !w;
    @(posedge clk);
    while (hrdy !== 1'h1) @(posedge clk);
    rd_ph <= 1'h0;
    hsel <= 1'h0;
  endtask
  initial begin
    #40000;
    fails++;
    conclude();
  end
  // -------- main sequence --------
  initial begin
    void'($urandom(36104));
    {resetn, hsel, hwrite, rd_ph, htrans, hsize, haddr, hwdata} = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    bus(0, `UI_OFS_ST_FLAGS, 8'h00);
    bus(0, `UI_OFS_ST_EN, 8'h00);
    bus(0, `UI_OFS_ER_FLAGS, 8'h00);
    bus(0, `UI_OFS_ER_EN, 8'h00);
    bus(0, `UI_OFS_CTRL, 8'h04);
    repeat (4) begin
      r = 8'($urandom);
      bus(1, `UI_OFS_ST_EN, r);
      bus(0, `UI_OFS_ST_EN, r & 8'h7F);
      bus(1, `UI_OFS_ER_EN, r);
      bus(0, `UI_OFS_ER_EN, r & 8'h9F);
    end
    bus(1, 12'h014, 8'hFF);
    bus(0, 12'h014, 8'h00);
    bus(1, `UI_OFS_ST_EN, 8'h02);
    bus(1, `UI_OFS_ER_EN, 8'h00);
    for (int k = 0; k < 5; k++) begin
      m = 8'h01 << ((k == 4) ? 7 : k);
      i_sie.err(k);
      #1 `CHK(erf, m)
      `CHK(irq, 1'h0)
      bus(1, `UI_OFS_ER_EN, m);
      #1 `CHK(irq, 1'h1)
      bus(0, `UI_OFS_ST_FLAGS, 8'h02);
      bus(1, `UI_OFS_ST_FLAGS, 8'h00);
      #1 `CHK(irq, 1'h1)
      bus(1, `UI_OFS_ER_FLAGS, 8'hFF);
      #1 `CHK(erf, m)
      bus(1, `UI_OFS_ER_FLAGS, ~m);
      #1 `CHK(erf, 8'h00)
      `CHK(irq, 1'h0)
      bus(1, `UI_OFS_ER_EN, 8'h00);
    end
    bus(1, `UI_OFS_ST_EN, 8'h00);
    for (int k = 0; k < 6; k++) begin
      m = 8'h01 << ((k == 0) ? 0 : k + 1);
      i_sie.st(k);
      #1 `CHK(stf, m)
      `CHK(irq, 1'h0)
      bus(1, `UI_OFS_ST_EN, m);
      #1 `CHK(irq, 1'h1)
      bus(1, `UI_OFS_ST_FLAGS, 8'h00);
      #1 `CHK(irq, 1'h0)
      bus(1, `UI_OFS_ST_FLAGS, m);
      #1 `CHK(stf, m)
      bus(1, `UI_OFS_ST_FLAGS, 8'h00);
      bus(1, `UI_OFS_ST_EN, 8'h00);
    end
    bus(1, `UI_OFS_ST_FLAGS, 8'h02);
    bus(0, `UI_OFS_ST_FLAGS, 8'h00);
    i_sie.eop(1'h1, 1'h1);
    i_sie.ticks(20);
    i_sie.eop(1'h0, 1'h0);
    i_sie.ticks(20);
    #1 `CHK(erf, 8'h00)
    i_sie.eop(1'h1, 1'h0);
    i_sie.ticks(16);
    #1 `CHK(erf, 8'h00)
    i_sie.ticks(1);
    #1 `CHK(erf, 8'h10)
    bus(1, `UI_OFS_ER_FLAGS, 8'h00);
    bus(1, `UI_OFS_CTRL, 8'h01);
    i_sie.st(1);
    bus(1, `UI_OFS_ST_FLAGS, 8'h00);
    #1 `CHK(stf, 8'h04)
    `CHK(rdy, 1'h0)
    bus(1, `UI_OFS_CTRL, 8'h00);
    bus(1, `UI_OFS_ST_FLAGS, 8'h00);
    #1 `CHK(stf, 8'h04)
    n = 0;
    while (stf[2] === 1'h1 && n < 8) begin
      bus(1, `UI_OFS_ST_FLAGS, 8'h00);
      #1 n++;
    end
    `CHK(stf, 8'h00)
    `CHK(rdy, 1'h1)
    i_sie.lock(1'h0);
    bus(1, `UI_OFS_CTRL, 8'h03);
    bus(1, `UI_OFS_CTRL, 8'h02);
    repeat (20) @(posedge clk);
    #1 `CHK(rdy, 1'h0)
    bus(0, `UI_OFS_CTRL, 8'h02);
    i_sie.lock(1'h1);
    repeat (12) @(posedge clk);
    #1 `CHK(rdy, 1'h1)
    bus(0, `UI_OFS_CTRL, 8'h06);
    conclude();
  end
endmodule
bind ui_irq_core ui_irq_core_monitor i_mon (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
  .i_stat_ev(i_stat_ev), .i_err_ev(i_err_ev), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_module_irq_request(o_module_irq_request), .o_usb_status_flags(o_usb_status_flags),
  .o_usb_error_flags(o_usb_error_flags), .o_suspend_control(o_suspend_control),
  .o_module_ready(o_module_ready));
